// ==== src/sfr_classify.v ====
`include "sfr_defines.vh"
// Maps a detected condition to vector, error code and saved pointer
module sfr_classify (
	// Condition
	input wire [`SFR_SRC_W-1:0] src,
	input wire [`SFR_SEL_W-1:0] sel,
	input wire ext_evt,
	input wire idt_ref,
	input wire in_switch,
	input wire post_commit,
	input wire ss_reg,
	// Result
	output reg [`SFR_VEC_W-1:0] vec,
	output reg [`SFR_ERR_W-1:0] err,
	output reg [`SFR_PTR_W-1:0] ptr
);
	// Error code with selector index and flags
	function [`SFR_ERR_W-1:0] mk_err;
		input [`SFR_SEL_W-1:0] s;
		input e;
		input i;
		begin
			mk_err = `SFR_ERR_ZERO;
			mk_err[`SFR_ERR_IDX_HI:`SFR_ERR_IDX_LO] =
				s[`SFR_ERR_IDX_HI:`SFR_ERR_IDX_LO];
			mk_err[`SFR_ERR_EXT] = e;
			mk_err[`SFR_ERR_IDT] = i;
		end
	endfunction

	// Vector and pointer choice per source
	always @* begin
		vec = `SFR_VEC_NP;
		err = mk_err(sel, ext_evt, idt_ref);
		ptr = `SFR_PTR_FAULT;
		case (src)
		`SFR_SRC_SEG: begin
			if (ss_reg) begin
				vec = `SFR_VEC_SS;
				err = mk_err(sel, ext_evt, 1'b0);
			end
			if (in_switch)
				ptr = `SFR_PTR_NEWTASK;
		end
		`SFR_SRC_SS_LOAD: begin
			vec = `SFR_VEC_SS;
			err = mk_err(sel, ext_evt, 1'b0);
			if (in_switch)
				ptr = `SFR_PTR_NEWTASK;
		end
		`SFR_SRC_LOAD_LOCAL_TABLE_INSTR: vec = `SFR_VEC_NP;
		`SFR_SRC_LTR: vec = `SFR_VEC_NP;
		`SFR_SRC_GATE: vec = `SFR_VEC_NP;
		`SFR_SRC_SS_LIMIT: begin
			vec = `SFR_VEC_SS;
			err = `SFR_ERR_ZERO;
		end
		`SFR_SRC_SS_NEWSTK: begin
			vec = `SFR_VEC_SS;
			err = mk_err(sel, ext_evt, 1'b0);
		end
		`SFR_SRC_TS_BAD, `SFR_SRC_LOCAL_TABLE_REGISTER_TS: begin
			vec = `SFR_VEC_TS;
			err = mk_err(sel, ext_evt, 1'b0);
			ptr = post_commit ? `SFR_PTR_NEWTASK
				: `SFR_PTR_SWITCH;
		end
		default: begin
			vec = `SFR_VEC_NP;
		end
		endcase
	end
endmodule

// ==== src/sfr_defines.vh ====
`ifndef SFR_DEFINES_VH
`define SFR_DEFINES_VH
// Exception vectors
`define SFR_VEC_W 8
`define SFR_VEC_TS 8'h0A
`define SFR_VEC_NP 8'h0B
`define SFR_VEC_SS 8'h0C
`define SFR_VEC_NONE 8'h00
// Error code layout: external-event flag, table-origin flag, index
`define SFR_ERR_W 16
`define SFR_ERR_EXT 0
`define SFR_ERR_IDT 1
`define SFR_ERR_IDX_LO 3
`define SFR_ERR_IDX_HI 15
`define SFR_ERR_ZERO 16'h0000
`define SFR_SEL_W 16
// Saved-pointer selection
`define SFR_PTR_W 2
`define SFR_PTR_FAULT 2'h0
`define SFR_PTR_SWITCH 2'h1
`define SFR_PTR_NEWTASK 2'h2
// Fault source kinds
`define SFR_SRC_W 4
`define SFR_SRC_SEG 4'h0
`define SFR_SRC_SS_LOAD 4'h1
`define SFR_SRC_LOAD_LOCAL_TABLE_INSTR 4'h2
`define SFR_SRC_LTR 4'h3
`define SFR_SRC_GATE 4'h4
`define SFR_SRC_SS_LIMIT 4'h5
`define SFR_SRC_SS_NEWSTK 4'h6
`define SFR_SRC_TS_BAD 4'h7
`define SFR_SRC_LOCAL_TABLE_REGISTER_TS 4'h8
// Segment register count during a task switch
`define SFR_NSEG 6
`define SFR_SEGIDX_W 3
`define SFR_SEGIDX_ZERO 3'h0
`define SFR_SEGIDX_ONE 3'h1
`define SFR_SEGIDX_LAST 3'h5
`endif

// ==== src/sfr_unit.v ====
`include "sfr_defines.vh"
module sfr_unit (
	// Clock and reset
	input wire sys_clk,
	input wire nrst,
	input wire clk_en,
	// Single segment or table load outside a task switch
	input wire load_req,
	input wire [`SFR_SRC_W-1:0] load_src,
	input wire [`SFR_SEL_W-1:0] load_sel,
	input wire load_present,
	input wire load_ss,
	input wire load_ext,
	input wire load_idt,
	// Stack limit checks
	input wire stk_limit_viol,
	input wire stk_newstk_viol,
	input wire [`SFR_SEL_W-1:0] stk_sel,
	// Task switch sequencer
	input wire sw_start,
	input wire sw_ext,
	input wire sw_pre_bad,
	input wire [`SFR_SEL_W-1:0] sw_pre_sel,
	input wire sw_commit,
	input wire sw_ldt_present,
	input wire [`SFR_SEL_W-1:0] sw_ldt_sel,
	input wire [`SFR_SEL_W-1:0] sw_seg_sel,
	input wire sw_seg_present,
	input wire sw_seg_valid,
	// Dispatch handshake
	input wire exc_ack,
	// Outputs toward the core
	output reg reg_load,
	output reg instr_suppress,
	output reg state_load,
	output reg [`SFR_SEGIDX_W-1:0] seg_idx,
	output reg sw_done,
	output reg exc_valid,
	output reg [`SFR_VEC_W-1:0] exc_vec,
	output reg [`SFR_ERR_W-1:0] exc_err,
	output reg [`SFR_PTR_W-1:0] exc_ptr
);
	localparam ST_IDLE = 2'h0;
	localparam ST_PRE = 2'h1;
	localparam ST_LOAD = 2'h2;
	localparam ST_CHECK = 2'h3;

	reg [1:0] st_reg;
	reg [1:0] st_next;
	reg [`SFR_SEGIDX_W-1:0] idx_next;
	reg flt_reg;
	reg flt_next;
	reg ext_reg;
	reg [`SFR_SEL_W-1:0] fsel_reg;
	reg [`SFR_SEL_W-1:0] fsel_next;
	reg [`SFR_SRC_W-1:0] fsrc_reg;
	reg [`SFR_SRC_W-1:0] fsrc_next;
	reg fss_reg;
	reg fss_next;
	reg raise;
	reg [`SFR_SRC_W-1:0] c_src;
	reg [`SFR_SEL_W-1:0] c_sel;
	reg c_ext;
	reg c_idt;
	reg c_sw;
	reg c_post;
	reg c_ss;
	wire [`SFR_VEC_W-1:0] cl_vec;
	wire [`SFR_ERR_W-1:0] cl_err;
	wire [`SFR_PTR_W-1:0] cl_ptr;

	// Last segment slot of the switch sequence
	function is_last;
		input [`SFR_SEGIDX_W-1:0] i;
		begin
			is_last = (i == `SFR_SEGIDX_LAST);
		end
	endfunction

	// Stack segment sits in slot one of the sequence
	function is_ss_slot;
		input [`SFR_SEGIDX_W-1:0] i;
		begin
			is_ss_slot = (i == `SFR_SEGIDX_ONE);
		end
	endfunction

	sfr_classify u_cls (
		.src(c_src),
		.sel(c_sel),
		.ext_evt(c_ext),
		.idt_ref(c_idt),
		.in_switch(c_sw),
		.post_commit(c_post),
		.ss_reg(c_ss),
		.vec(cl_vec),
		.err(cl_err),
		.ptr(cl_ptr)
	);

	// Switch sequencing and fault capture
	always @* begin
		st_next = st_reg;
		idx_next = seg_idx;
		flt_next = flt_reg;
		fsel_next = fsel_reg;
		fsrc_next = fsrc_reg;
		fss_next = fss_reg;
		raise = 1'b0;
		c_src = `SFR_SRC_SEG;
		c_sel = load_sel;
		c_ext = load_ext;
		c_idt = load_idt;
		c_sw = 1'b0;
		c_post = 1'b0;
		c_ss = load_ss;
		case (st_reg)
		ST_IDLE: begin
			if (sw_start && !exc_valid) begin
				st_next = ST_PRE;
				flt_next = 1'b0;
			end else if (!exc_valid) begin
				if (stk_limit_viol) begin
					raise = 1'b1;
					c_src = `SFR_SRC_SS_LIMIT;
					c_sel = stk_sel;
				end else if (stk_newstk_viol) begin
					raise = 1'b1;
					c_src = `SFR_SRC_SS_NEWSTK;
					c_sel = stk_sel;
				end else if (load_req && !load_present) begin
					raise = 1'b1;
					c_src = load_src;
				end
			end
		end
		ST_PRE: begin
			// Until commit, a bad task segment leaves state alone
			c_ext = ext_reg;
			c_sel = sw_pre_sel;
			c_src = `SFR_SRC_TS_BAD;
			c_ss = 1'b0;
			if (sw_pre_bad) begin
				raise = 1'b1;
				st_next = ST_IDLE;
			end else if (sw_commit) begin
				st_next = ST_LOAD;
				idx_next = `SFR_SEGIDX_ZERO;
				if (!sw_ldt_present) begin
					flt_next = 1'b1;
					fsrc_next = `SFR_SRC_LOCAL_TABLE_REGISTER_TS;
					fsel_next = sw_ldt_sel;
				end
			end
		end
		ST_LOAD: begin
			// All selectors are loaded before any is checked
			if (is_last(seg_idx)) begin
				st_next = ST_CHECK;
				idx_next = `SFR_SEGIDX_ZERO;
			end else
				idx_next = seg_idx + `SFR_SEGIDX_ONE;
		end
		ST_CHECK: begin
			// Once one fault is held, later slots go unchecked
			if (!flt_reg) begin
				if (!sw_seg_present) begin
					flt_next = 1'b1;
					fsrc_next = `SFR_SRC_SEG;
					fsel_next = sw_seg_sel;
					fss_next = is_ss_slot(seg_idx);
				end else if (!sw_seg_valid) begin
					flt_next = 1'b1;
					fsrc_next = `SFR_SRC_TS_BAD;
					fsel_next = sw_seg_sel;
					fss_next = 1'b0;
				end
			end
			if (is_last(seg_idx)) begin
				st_next = ST_IDLE;
				raise = flt_next;
			end else
				idx_next = seg_idx + `SFR_SEGIDX_ONE;
			c_src = fsrc_next;
			c_sel = fsel_next;
			c_ext = ext_reg;
			c_idt = 1'b0;
			c_sw = 1'b1;
			c_post = 1'b1;
			c_ss = fss_next;
		end
		default: st_next = ST_IDLE;
		endcase
	end

	// State and dispatch registers
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_reg <= ST_IDLE;
			seg_idx <= `SFR_SEGIDX_ZERO;
			flt_reg <= 1'b0;
			ext_reg <= 1'b0;
			fsel_reg <= `SFR_ERR_ZERO;
			fsrc_reg <= `SFR_SRC_SEG;
			fss_reg <= 1'b0;
			reg_load <= 1'b0;
			instr_suppress <= 1'b0;
			state_load <= 1'b0;
			sw_done <= 1'b0;
			exc_valid <= 1'b0;
			exc_vec <= `SFR_VEC_NONE;
			exc_err <= `SFR_ERR_ZERO;
			exc_ptr <= `SFR_PTR_FAULT;
		end else if (clk_en) begin
			st_reg <= st_next;
			seg_idx <= idx_next;
			flt_reg <= flt_next;
			fsel_reg <= fsel_next;
			fsrc_reg <= fsrc_next;
			fss_reg <= fss_next;
			if (st_reg == ST_IDLE && sw_start)
				ext_reg <= sw_ext;
			// A present segment loads; an absent one stays out
			reg_load <= (st_reg == ST_IDLE) && load_req &&
				load_present && !exc_valid;
			// Any raised fault in normal flow cancels the instr
			instr_suppress <= raise && (st_reg == ST_IDLE);
			// New-task state loads only past the commit point
			// Follows the next state so it lines up with slots 0..5
			state_load <= (st_next == ST_LOAD);
			sw_done <= (st_reg == ST_CHECK) && is_last(seg_idx) &&
				!flt_next;
			if (exc_valid && exc_ack)
				exc_valid <= 1'b0;
			else if (raise && !exc_valid) begin
				exc_valid <= 1'b1;
				exc_vec <= cl_vec;
				exc_err <= cl_err;
				exc_ptr <= cl_ptr;
			end
		end
	end
endmodule

// ==== tb/sfr_core_model.sv ====
module sfr_core_model (
	// Clock and reset
	input wire sys_clk,
	input wire nrst,
	// Dispatch side
	input wire exc_valid,
	input wire [1:0] lat,
	output logic exc_ack
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] wait_reg;
	// Takes one request after lat cycles; ack is a single cycle
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			exc_ack <= 1'h0;
			wait_reg <= 2'h0;
		end else if (exc_ack) begin
			exc_ack <= 1'h0;
			wait_reg <= 2'h0;
		end else if (exc_valid) begin
			exc_ack <= (wait_reg == lat);
			wait_reg <= wait_reg + 2'h1;
		end
	end
	// Handler reloads segments as its own task, outside this model
endmodule

// ==== tb/sfr_unit_chk.sv ====
`include "sfr_defines.vh"
module sfr_unit_chk (
	// Clock and reset
	input wire sys_clk,
	input wire nrst,
	input wire clk_en,
	// Requests
	input wire load_req,
	input wire load_present,
	input wire load_ss,
	input wire [`SFR_SRC_W-1:0] load_src,
	input wire stk_limit_viol,
	input wire stk_newstk_viol,
	input wire [`SFR_SEL_W-1:0] stk_sel,
	input wire sw_start,
	input wire sw_pre_bad,
	input wire exc_ack,
	// Results
	input wire reg_load,
	input wire instr_suppress,
	input wire state_load,
	input wire [`SFR_SEGIDX_W-1:0] seg_idx,
	input wire exc_valid,
	input wire [`SFR_VEC_W-1:0] exc_vec,
	input wire [`SFR_ERR_W-1:0] exc_err,
	input wire [`SFR_PTR_W-1:0] exc_ptr
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);
	// Loads count only when idle; never driven mid-switch
	wire quiet = !exc_valid && !stk_limit_viol && !stk_newstk_viol;
	a_limit_code: assert property (
		stk_limit_viol && !exc_valid |=> exc_valid && instr_suppress &&
		exc_vec == `SFR_VEC_SS && exc_err == `SFR_ERR_ZERO)
		else $error("limit fault answer wrong");
	a_newstk_sel: assert property (
		!stk_limit_viol && stk_newstk_viol && !exc_valid |=>
		exc_vec == `SFR_VEC_SS && exc_err[15:3] == $past(stk_sel[15:3]))
		else $error("new stack fault code wrong");
	a_absent_seg: assert property (
		quiet && load_req && !load_present && !load_ss &&
		load_src == `SFR_SRC_SEG |=>
		exc_valid && exc_vec == `SFR_VEC_NP && !reg_load)
		else $error("absent segment answer wrong");
	a_absent_ss: assert property (
		quiet && load_req && !load_present && load_src == `SFR_SRC_SS_LOAD
		|=> exc_valid && exc_vec == `SFR_VEC_SS)
		else $error("absent stack answer wrong");
	a_load_ok: assert property (
		quiet && load_req && load_present && load_src == `SFR_SRC_SEG
		|=> reg_load && !exc_valid)
		else $error("present load not taken");
	a_req_hold: assert property (
		exc_valid && !exc_ack |=> exc_valid && $stable(exc_err) &&
		$stable(exc_vec) && $stable(exc_ptr))
		else $error("request changed before ack");
	a_freeze_hold: assert property (
		!clk_en |=> $stable(exc_valid) && $stable(exc_vec) &&
		$stable(exc_err) && $stable(reg_load) &&
		$stable(instr_suppress) && $stable(state_load) &&
		$stable(seg_idx))
		else $error("outputs moved while frozen");
	a_ack_clear: assert property (
		exc_valid && exc_ack |=> !exc_valid)
		else $error("request kept after ack");
	a_load_span: assert property (
		$rose(state_load) |-> state_load [*6] ##1
		(!state_load && seg_idx == `SFR_SEGIDX_ZERO))
		else $error("load phase length wrong");
	a_pre_commit: assert property (
		$past(sw_start) && sw_pre_bad |=> exc_valid && !state_load &&
		exc_vec == `SFR_VEC_TS && exc_ptr == `SFR_PTR_SWITCH)
		else $error("early switch fault wrong");
endmodule

// ==== tb/sfr_unit_tb_top.sv ====
`include "sfr_defines.vh"
module sfr_unit_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	// Design inputs, idle at time zero
	logic sys_clk = 1'h0, nrst = 1'h0, clk_en = 1'h1, load_req = 1'h0;
	logic load_present = 1'h0, load_ss = 1'h0, load_ext = 1'h0;
	logic load_idt = 1'h0, stk_limit_viol = 1'h0, stk_newstk_viol = 1'h0;
	logic sw_start = 1'h0, sw_ext = 1'h0, sw_pre_bad = 1'h0;
	logic sw_commit = 1'h0, sw_ldt_present = 1'h1, np = 1'h0;
	logic [3:0] load_src = 4'h0;
	logic [15:0] load_sel = 16'h0, stk_sel = 16'h0, sw_pre_sel = 16'h0;
	logic [15:0] sw_ldt_sel = 16'h0, base = 16'h0;
	logic [2:0] bad = 3'h7;
	logic [1:0] lat = 2'h0;
	// Design outputs and bench state
	wire sw_seg_present, sw_seg_valid, exc_ack, reg_load, instr_suppress;
	wire state_load, sw_done, exc_valid;
	wire [2:0] seg_idx;
	wire [7:0] exc_vec;
	wire [15:0] exc_err, sw_seg_sel;
	wire [1:0] exc_ptr;
	int mismatches = 0, cmp_count = 0, cyc = 0, nload = 0, k;
	logic sup_seen = 1'h0, rl_seen = 1'h0;
	// Slots from the bad one on all fail, so a late check shows in the code
	assign sw_seg_sel = {base[15:6], seg_idx, 3'h0};
	assign sw_seg_present = !(np && seg_idx >= bad);
	assign sw_seg_valid = !(!np && seg_idx >= bad);
	sfr_unit dut (.*);
	sfr_core_model u_core (.*);
	always #5 sys_clk = ~sys_clk;
	// Pulse monitors and hang guard
	always @(posedge sys_clk) begin
		nload += state_load;
		sup_seen |= instr_suppress;
		rl_seen |= reg_load;
		cyc++;
		if (cyc == 6000) begin
			mismatches++;
			results();
		end
	end
	task results();
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(string n, logic [15:0] e, logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	// Waits for a request or a clean end, checks it, lets dispatch take it
	task expect_exc(logic [7:0] v, logic [15:0] e, logic [15:0] m,
		logic [1:0] p, logic s);
		int n;
		n = 0;
		while (exc_valid !== 1'h1 && sw_done !== 1'h1 && n < 40) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk("valid", 16'(v != `SFR_VEC_NONE), 16'(exc_valid));
		if (v != `SFR_VEC_NONE) begin
			chk("vec", 16'(v), 16'(exc_vec));
			chk("err", e & m, exc_err & m);
			chk("ptr", 16'(p), 16'(exc_ptr));
			while (exc_valid === 1'h1 && n < 80) begin
				@(posedge sys_clk);
				#1;
				n++;
			end
			chk("suppress", 16'(s), 16'(sup_seen));
		end
	endtask
	// Limit, new stack, then loads: seg, seg as stack, stack, tables, gate
	task single(int k);
		logic [15:0] s;
		logic x, i, pr;
		s = $urandom;
		x = $urandom;
		i = $urandom;
		pr = (k > 1) && ($urandom % 2);
		sup_seen = 1'h0;
		rl_seen = 1'h0;
		@(posedge sys_clk);
		{stk_sel, load_sel, load_ext, load_idt} <= {s, s, x, i};
		stk_limit_viol <= (k == 0);
		stk_newstk_viol <= (k == 1) || (k == 0 && x);
		load_src <= (k < 4) ? `SFR_SRC_SEG : 4'(k - 3);
		{load_req, load_present, load_ss} <= {k > 1, pr, k == 3};
		@(posedge sys_clk);
		{load_req, stk_limit_viol, stk_newstk_viol} <= 3'h0;
		// A random one-cycle freeze right after the request must lose nothing
		clk_en <= 1'($urandom % 2);
		@(posedge sys_clk);
		clk_en <= 1'h1;
		#1;
		if (pr) begin
			repeat (2) @(posedge sys_clk);
			#1;
			chk("idle", 16'h0, 16'(exc_valid));
			if (k < 5) chk("loaded", 16'h1, 16'(rl_seen));
		end else if (k == 0)
			expect_exc(`SFR_VEC_SS, 16'h0, 16'hFFFF, 0, 1);
		else if (k == 1 || k == 3 || k == 4)
			expect_exc(`SFR_VEC_SS, s, 16'hFFF8, 0, 1);
		else
			expect_exc(`SFR_VEC_NP, {s[15:3], 1'h0, i, x}, 16'hFFFB,
				0, 1);
		if (!pr) chk("loaded", 16'h0, 16'(rl_seen));
	endtask
	// One task switch: bad slot b (7 none), absent or invalid, table, early
	task sw(logic [2:0] b, logic n, logic lok, logic pre);
		logic [15:0] s;
		logic x;
		s = $urandom;
		x = $urandom;
		@(posedge sys_clk);
		{bad, np, base, sw_ldt_present, sw_ldt_sel} <= {b, n, s, lok, s};
		{sw_pre_sel, sw_ext, sw_start} <= {s, x, 1'h1};
		@(posedge sys_clk);
		{sw_start, sw_pre_bad, sw_commit} <= {1'h0, pre, !pre};
		nload = 0;
		sup_seen = 1'h0;
		@(posedge sys_clk);
		{sw_pre_bad, sw_commit} <= 2'h0;
		if (pre)
			expect_exc(`SFR_VEC_TS, {s[15:3], 2'h0, x}, 16'hFFFB,
				`SFR_PTR_SWITCH, 0);
		else if (!lok)
			expect_exc(`SFR_VEC_TS, s, 16'hFFF8, 2, 0);
		else if (b == 3'h7) begin
			expect_exc(`SFR_VEC_NONE, 16'h0, 16'h0, 0, 0);
			chk("done", 16'h1, 16'(sw_done));
		end else
			expect_exc(n ? (b == 3'h1 ? `SFR_VEC_SS : `SFR_VEC_NP) :
				`SFR_VEC_TS, {s[15:6], b, 3'h0}, 16'hFFF8, 2,
				0);
		chk("loads", pre ? 16'h0 : 16'h6, 16'(nload));
	endtask
	initial begin
		k = $urandom(32'hB8F35A50);
		repeat (16) @(posedge sys_clk);
		nrst <= 1'h1;
		repeat (2) @(posedge sys_clk);
		for (k = 0; k < 64; k++) begin
			lat <= $urandom;
			single(k < 8 ? k : $urandom % 8);
		end
		sw(3'h0, 0, 1, 1);
		sw(3'h7, 0, 1, 0);
		sw(3'h7, 0, 0, 0);
		sw(3'h1, 1, 1, 0);
		repeat (12) sw(3'($urandom % 6), $urandom, 1, 0);
		results();
	end
endmodule
bind sfr_unit sfr_unit_chk u_chk (.*);
